// ### pkg/mbm_pkg.sv
// How it works
// - pin_as_input routes pin onto bus, off at reset
// - pin_as_output drives pin from bus, off at reset
// - reduced build limits pin directions
// - each target picks one bus, default a
// - each source picks one bus, default a
// - shared source 0 has one enable for both cpu break and halt broadcast
// - halt broadcast drives cpu halt level
// - range conversion by core version
// - event counters count, sample at zero
// - counterless build samples every event
// - external break halts cpu on bus
// - external break turns trace actions into halt
// - suspend routed to none or one of eight
// - reset command restores all defaults
// - software break halts on debug instruction
// - disabled software break makes debug nop
// - suspend gate enable gates forwarding
// - direct passes level, capture latches falling edge
// - force asserts suspend always
package mbm_pkg;
    localparam int unsigned NUM_SRC = 7;
    localparam int unsigned NUM_TGT = 3;
    localparam int unsigned NUM_TRIG = 8;
    localparam int unsigned CNT_W = 16;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_SRCSEL = 8'h04;
    localparam logic [7:0] ADR_SRCEN = 8'h08;
    localparam logic [7:0] ADR_SUSP = 8'h0c;
    localparam logic [7:0] ADR_CNTX = 8'h10;
    localparam logic [7:0] ADR_CNTY = 8'h14;
    localparam logic [7:0] ADR_STAT = 8'h18;
    localparam logic [7:0] ADR_CMD = 8'h1c;
    localparam int unsigned CMD_RESET = 0;
    localparam int unsigned CMD_CLEAR = 1;
    localparam logic [2:0] SUSP_NONE = 3'h0;
    typedef enum logic [1:0] {
        MBM_CAPTURE = 2'h1,
        MBM_DIRECT = 2'h2
    } mbm_mode_e;
    typedef struct packed {
        logic       in_a;
        logic       in_b;
        logic       out_a;
        logic       out_b;
        logic       halt_bc;
        logic       ext_brk;
        logic       sw_brk;
        logic       convert;
        logic [2:0] tgt_sel;
    } mbm_ctrl_s;
    localparam mbm_ctrl_s CTRL_RST = '{in_a: 1'b0, in_b: 1'b0, out_a: 1'b0, out_b: 1'b0, halt_bc: 1'b0,
                                       ext_brk: 1'b0, sw_brk: 1'b1, convert: 1'b0, tgt_sel: 3'h0};
    typedef struct packed {
        logic       en;
        logic       force_on;
        logic       direct;
        logic [3:0] route;
    } mbm_susp_s;
    localparam mbm_susp_s SUSP_RST = '{en: 1'b0, force_on: 1'b0, direct: 1'b0, route: 4'h0};
endpackage

// ### rtl/mbm_evcnt.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_evcnt
    import mbm_pkg::*;
#(
    parameter int unsigned W = CNT_W,
    parameter bit HAS_CNT = 1'b1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         event_i,
    input  wire logic [3:0]   status_i,
    output logic [W-1:0]      count_o,
    output logic [3:0]        sample_o
);
    logic [W-1:0] cnt_reg;
    logic [3:0]   smp_reg;
    wire          take = event_i && (!HAS_CNT || cnt_reg == '0);
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_reg <= '0;
            smp_reg <= 4'h0;
        end else begin
            if (load_i) begin
                cnt_reg <= load_val_i;
            end else if (event_i && HAS_CNT) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (take) begin
                smp_reg <= status_i;
            end
        end
    end
    assign count_o = cnt_reg;
    assign sample_o = smp_reg;
endmodule // mbm_evcnt
`default_nettype wire

// ### rtl/mbm_break_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_break_matrix
    import mbm_pkg::*;
#(
    parameter bit REDUCED = 1'b0,
    parameter bit EXT_ALWAYS = 1'b0,
    parameter bit HAS_CNT = 1'b1,
    parameter bit NEW_CORE = 1'b1
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic [31:0]              dat_o,
    output logic                     ack_o,
    input  wire logic                break_in_pin_i,
    output logic                     break_in_pin_o,
    output logic                     break_in_pin_oe_o,
    input  wire logic                break_out_pin_i,
    output logic                     break_out_pin_o,
    output logic                     break_out_pin_oe_o,
    input  wire logic [NUM_SRC-1:0]  src_brk_i,
    input  wire logic                cpu_halted_i,
    input  wire logic                debug_instr_i,
    input  wire logic                trace_action_i,
    input  wire logic                range_bp_i,
    input  wire logic                range_single_i,
    input  wire logic                ev_x_i,
    input  wire logic                ev_y_i,
    input  wire logic [3:0]          ev_status_i,
    output logic                     cpu_halt_req_o,
    output logic                     cpu_debug_nop_o,
    output logic                     trace_ctrl_en_o,
    output logic                     range_to_single_o,
    output logic                     trace_brk_n_o,
    output logic                     suspend_o,
    output logic [NUM_TRIG-1:0]      trigger_out_o
);
    mbm_ctrl_s              ctrl_reg;
    mbm_susp_s              susp_reg;
    logic [NUM_SRC-1:0]     srcsel_reg;
    logic [NUM_SRC-1:0]     srcen_reg;
    logic [1:0]             sin_a_reg, sout_a_reg;
    logic                   sg_prev_reg, cap_reg, ack_reg;
    logic [31:0]            dat_reg;
    logic                   halt_req_reg, nop_reg, trc_reg, conv_reg, trcbrk_reg, susp_out_reg;
    logic                   pin_in_oe_reg, pin_out_oe_reg;
    logic [NUM_TRIG-1:0]    trig_reg;
    logic [CNT_W-1:0]       cnt_x, cnt_y;
    logic [3:0]             smp_x, smp_y;
    // bus slave decode
    wire req = cyc_i && stb_i && !ack_reg;
    wire wr = req && we_i;
    wire wr_ctrl = wr && adr_i == ADR_CTRL && sel_i[1:0] == 2'h3;
    wire wr_src = wr && adr_i == ADR_SRCSEL && sel_i[0];
    wire wr_en = wr && adr_i == ADR_SRCEN && sel_i[0];
    wire wr_susp = wr && adr_i == ADR_SUSP && sel_i[0];
    wire wr_cx = wr && adr_i == ADR_CNTX && sel_i[1:0] == 2'h3;
    wire wr_cy = wr && adr_i == ADR_CNTY && sel_i[1:0] == 2'h3;
    wire wr_cmd = wr && adr_i == ADR_CMD && sel_i[0];
    wire cmd_rst = wr_cmd && dat_i[CMD_RESET];
    wire cmd_clr = wr_cmd && dat_i[CMD_CLEAR];
    // synchronised pins, active low
    wire pin_in_act = !sin_a_reg[1];
    wire pin_out_act = !sout_a_reg[1];
    // effective pin directions
    wire use_in_a = ctrl_reg.in_a;
    wire use_in_b = ctrl_reg.in_b && !REDUCED;
    wire use_out_a = ctrl_reg.out_a && !REDUCED;
    wire use_out_b = ctrl_reg.out_b;
    // sources onto buses
    logic [NUM_SRC-1:0] src_act;
    logic [NUM_SRC-1:0] on_a, on_b;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            if (g == 0) begin : g_cpu
                assign src_act[g] = srcen_reg[g] && (src_brk_i[g] || (ctrl_reg.halt_bc && cpu_halted_i));
            end else begin : g_oth
                assign src_act[g] = srcen_reg[g] && src_brk_i[g];
            end
            assign on_a[g] = src_act[g] && !srcsel_reg[g];
            assign on_b[g] = src_act[g] && srcsel_reg[g];
        end
    endgenerate
    // wired buses, asserted when any driver active
    wire line_a = |on_a || (use_in_a && pin_in_act);
    wire line_b = |on_b || (use_in_b && pin_out_act);
    // targets pick a bus
    wire cpu_line = ctrl_reg.tgt_sel[0] ? line_b : line_a;
    wire trc_line = ctrl_reg.tgt_sel[1] ? line_b : line_a;
    wire sg_line = ctrl_reg.tgt_sel[2] ? line_b : line_a;
    wire ext_on = ctrl_reg.ext_brk || EXT_ALWAYS;
    wire halt_next = (ext_on && (cpu_line || trace_action_i)) || (ctrl_reg.sw_brk && debug_instr_i);
    wire sg_fall = sg_line && !sg_prev_reg; // bus level falls when it asserts
    wire cap_next = cmd_clr ? sg_fall : (cap_reg || sg_fall);
    wire sg_lvl = susp_reg.direct ? sg_line : cap_reg;
    wire susp_next = susp_reg.force_on || (susp_reg.en && sg_lvl);
    wire conv_next = ctrl_reg.convert && range_bp_i && (!NEW_CORE || range_single_i);
    logic [NUM_TRIG-1:0] trig_next;
    generate
        for (g = 0; g < NUM_TRIG; g++) begin : g_trig
            assign trig_next[g] = susp_reg.route == 4'(g + 1) && susp_out_reg;
        end
    endgenerate
    wire [31:0] rd_ctrl = {21'h0, ctrl_reg};
    wire [31:0] rd_stat = {18'h0, cap_reg, susp_out_reg, trc_line, cpu_line, line_b, line_a, smp_y, smp_x};
    logic [31:0] rd_mux;
    always_comb begin
        case (adr_i)
            ADR_CTRL: rd_mux = rd_ctrl;
            ADR_SRCSEL: rd_mux = {25'h0, srcsel_reg};
            ADR_SRCEN: rd_mux = {25'h0, srcen_reg};
            ADR_SUSP: rd_mux = {25'h0, susp_reg};
            ADR_CNTX: rd_mux = {16'h0, cnt_x};
            ADR_CNTY: rd_mux = {16'h0, cnt_y};
            ADR_STAT: rd_mux = rd_stat;
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        sin_a_reg <= {sin_a_reg[0], break_in_pin_i};
        sout_a_reg <= {sout_a_reg[0], break_out_pin_i};
        if (rst_i) begin
            sin_a_reg <= 2'h3;
            sout_a_reg <= 2'h3;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_rst) begin
            ctrl_reg <= CTRL_RST;
            susp_reg <= SUSP_RST;
            srcsel_reg <= '0;
            srcen_reg <= '1;
        end else begin
            if (wr_ctrl) ctrl_reg <= mbm_ctrl_s'(dat_i[10:0]);
            if (wr_susp) susp_reg <= mbm_susp_s'(dat_i[6:0]);
            if (wr_src) srcsel_reg <= dat_i[NUM_SRC-1:0];
            if (wr_en) srcen_reg <= dat_i[NUM_SRC-1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_rst) begin
            cap_reg <= 1'b0;
            sg_prev_reg <= 1'b0;
        end else begin
            cap_reg <= cap_next;
            sg_prev_reg <= sg_line;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= req;
            dat_reg <= req ? rd_mux : 32'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_req_reg <= 1'b0;
            nop_reg <= 1'b0;
            trc_reg <= 1'b1;
            conv_reg <= 1'b0;
            trcbrk_reg <= 1'b0;
            susp_out_reg <= 1'b0;
            trig_reg <= '0;
            pin_in_oe_reg <= 1'b0;
            pin_out_oe_reg <= 1'b0;
        end else begin
            halt_req_reg <= halt_next;
            nop_reg <= !ctrl_reg.sw_brk && debug_instr_i;
            trc_reg <= !ext_on;
            conv_reg <= conv_next;
            trcbrk_reg <= trc_line;
            susp_out_reg <= susp_next;
            trig_reg <= trig_next;
            pin_out_oe_reg <= use_out_b && line_b;
            pin_in_oe_reg <= use_out_a && line_a;
        end
    end
    mbm_evcnt #(.W(CNT_W), .HAS_CNT(HAS_CNT)) u_event_x_counter (
        .clk_i(clk_i), .rst_i(rst_i), .clr_i(cmd_rst), .load_i(wr_cx), .load_val_i(dat_i[CNT_W-1:0]),
        .event_i(ev_x_i), .status_i(ev_status_i), .count_o(cnt_x), .sample_o(smp_x)
    );
    mbm_evcnt #(.W(CNT_W), .HAS_CNT(HAS_CNT)) u_event_y_counter (
        .clk_i(clk_i), .rst_i(rst_i), .clr_i(cmd_rst), .load_i(wr_cy), .load_val_i(dat_i[CNT_W-1:0]),
        .event_i(ev_y_i), .status_i(ev_status_i), .count_o(cnt_y), .sample_o(smp_y)
    );
    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign break_in_pin_o = 1'b0;
    assign break_out_pin_o = 1'b0;
    assign break_in_pin_oe_o = pin_in_oe_reg;
    assign break_out_pin_oe_o = pin_out_oe_reg;
    assign cpu_halt_req_o = halt_req_reg;
    assign cpu_debug_nop_o = nop_reg;
    assign trace_ctrl_en_o = trc_reg;
    assign range_to_single_o = conv_reg;
    assign trace_brk_n_o = !trcbrk_reg;
    assign suspend_o = susp_out_reg;
    assign trigger_out_o = trig_reg;
endmodule // mbm_break_matrix
`default_nettype wire

// ### testbench/mbm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       break_in_pin_o,
    input wire logic       break_out_pin_o,
    input wire logic       break_in_pin_oe_o,
    input wire logic       break_out_pin_oe_o,
    input wire logic       cpu_halt_req_o,
    input wire logic       trace_ctrl_en_o,
    input wire logic       trace_brk_n_o,
    input wire logic       suspend_o,
    input wire logic [7:0] trigger_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("ack unasked");
    chk_pin_od: assert property (!break_in_pin_o && !break_out_pin_o) else $error("pin high");
    chk_pin_reset: assert property ($fell(rst_i) |-> (!break_in_pin_oe_o && !break_out_pin_oe_o) [*2])
        else $error("pin enabled after reset");
    chk_out_reset: assert property ($fell(rst_i) |->
        !suspend_o && !cpu_halt_req_o && trace_brk_n_o && trace_ctrl_en_o) else $error("output not idle");
    chk_trig_onehot: assert property ($onehot0(trigger_out_o)) else $error("two triggers");
    chk_trig_idle: assert property (!$past(suspend_o) |-> trigger_out_o == 8'h0) else $error("stray trigger");
endmodule // mbm_checker

bind mbm_break_matrix mbm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .break_in_pin_o(break_in_pin_o), .break_out_pin_o(break_out_pin_o), .break_in_pin_oe_o(break_in_pin_oe_o),
    .break_out_pin_oe_o(break_out_pin_oe_o), .cpu_halt_req_o(cpu_halt_req_o), .trace_ctrl_en_o(trace_ctrl_en_o),
    .trace_brk_n_o(trace_brk_n_o), .suspend_o(suspend_o), .trigger_out_o(trigger_out_o));
`default_nettype wire

// ### testbench/mbm_probe.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_probe (
    input  wire logic       in_oe_i,
    input  wire logic       out_oe_i,
    input  wire logic [1:0] pull_i,
    output logic            in_lvl_o,
    output logic            out_lvl_o
);
    // pulled-up open drain, low if anyone pulls
    assign in_lvl_o = ~(in_oe_i | pull_i[0]);
    assign out_lvl_o = ~(out_oe_i | pull_i[1]);
endmodule // mbm_probe
`default_nettype wire

// ### testbench/mbm_break_matrix_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mbm_break_matrix_bench;
    import mbm_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, range_bp_i, range_single_i;
    logic        in_lvl, out_lvl, in_oe, out_oe, halt, nop, tr_en, rng, tr_n, susp;
    logic        halt2, rng2, in_oe2;
    logic [1:0]  pull;
    logic [3:0]  pv, ev_status_i;
    logic [7:0]  src, adr_i, trigger_out_o;
    logic [15:0] v;
    logic [31:0] dat_i, dat_o, dat2, exp_q[$];
    int          fails = 0, num_checks = 0, cyc_cnt = 0;
    mbm_break_matrix dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .break_in_pin_i(in_lvl), .break_in_pin_o(),
        .break_in_pin_oe_o(in_oe), .break_out_pin_i(out_lvl), .break_out_pin_o(), .break_out_pin_oe_o(out_oe),
        .src_brk_i(src[6:0]), .cpu_halted_i(src[7]), .debug_instr_i(pv[0]), .trace_action_i(pv[1]),
        .range_bp_i(range_bp_i), .range_single_i(range_single_i), .ev_x_i(pv[2]), .ev_y_i(pv[3]),
        .ev_status_i(ev_status_i), .cpu_halt_req_o(halt), .cpu_debug_nop_o(nop), .trace_ctrl_en_o(tr_en),
        .range_to_single_o(rng), .trace_brk_n_o(tr_n), .suspend_o(susp), .trigger_out_o(trigger_out_o));
    // reduced build, permanent external break, counterless, old core
    mbm_break_matrix #(.REDUCED(1'b1), .EXT_ALWAYS(1'b1), .HAS_CNT(1'b0), .NEW_CORE(1'b0)) dut_reduced (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
        .dat_i(dat_i), .dat_o(dat2), .ack_o(), .break_in_pin_i(in_lvl), .break_in_pin_o(),
        .break_in_pin_oe_o(in_oe2), .break_out_pin_i(out_lvl), .break_out_pin_o(), .break_out_pin_oe_o(),
        .src_brk_i(src[6:0]), .cpu_halted_i(src[7]), .debug_instr_i(pv[0]), .trace_action_i(pv[1]),
        .range_bp_i(range_bp_i), .range_single_i(range_single_i), .ev_x_i(pv[2]), .ev_y_i(pv[3]),
        .ev_status_i(ev_status_i), .cpu_halt_req_o(halt2), .cpu_debug_nop_o(), .trace_ctrl_en_o(),
        .range_to_single_o(rng2), .trace_brk_n_o(), .suspend_o(), .trigger_out_o());
    mbm_probe probe (.in_oe_i(in_oe), .out_oe_i(out_oe), .pull_i(pull), .in_lvl_o(in_lvl), .out_lvl_o(out_lvl));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_i) pv <= m;
        @(posedge clk_i) pv <= 4'h0;
        #1;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk_i);
        if (!w) exp_q.push_back(d);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, w ? d : 32'h0};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        {cyc_i, stb_i} <= 2'b00;
    endtask
    // write control, raise sources and pins, compare the settled outputs
    task automatic scen(input logic [31:0] c, input logic [7:0] s, input logic [1:0] p, input logic [5:0] e);
        wb(1'b1, ADR_CTRL, c);
        @(posedge clk_i) {src, pull} <= {s, p};
        tick(5);
        chk({halt, tr_n, in_oe, out_oe, susp, tr_en}, e);
        @(posedge clk_i) {src, pull} <= '0;
        tick(5);
    endtask
    task automatic end_sim();
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            chk(dat_o, exp_q.pop_front());
        end
        if (cyc_cnt == 3000) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    end
    initial begin
        v = 16'($urandom(10027));
        {rst_i, cyc_i, stb_i, we_i, range_bp_i, range_single_i} = 6'h20;
        {pull, pv, ev_status_i, src, adr_i, dat_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h10);
        wb(1'b0, ADR_SRCEN, 32'h7f);
        wb(1'b0, ADR_SUSP, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        pulse(4'h1);
        chk({halt, nop}, 2'b10);
        wb(1'b1, ADR_CTRL, 32'h30);
        pulse(4'h2);
        chk(halt, 1'b1);
        wb(1'b1, ADR_CTRL, 32'h0);
        pulse(4'h1);
        chk({halt, nop}, 2'b01);
        scen(32'h430, 8'h0, 2'h1, 6'h20);
        scen(32'h431, 8'h0, 2'h1, 6'h00);
        scen(32'h432, 8'h0, 2'h1, 6'h30);
        scen(32'h212, 8'h0, 2'h2, 6'h01);
        scen(32'h110, 8'h4, 2'h0, 6'h09);
        wb(1'b1, ADR_SRCSEL, 32'h1);
        scen(32'h090, 8'h1, 2'h0, 6'h15);
        scen(32'h0d0, 8'h80, 2'h0, 6'h15);
        scen(32'h090, 8'h80, 2'h0, 6'h11);
        wb(1'b1, ADR_SRCEN, 32'h7e);
        scen(32'h090, 8'h1, 2'h0, 6'h11);
        wb(1'b1, ADR_SRCEN, 32'h7f);
        wb(1'b1, ADR_SUSP, 32'h50);
        scen(32'h010, 8'h4, 2'h0, 6'h03);
        wb(1'b1, ADR_SUSP, 32'h10);
        scen(32'h010, 8'h4, 2'h0, 6'h01);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, ADR_SUSP, 32'h61 + i);
            tick(3);
            chk({susp, trigger_out_o}, {1'b1, 8'h1 << i});
        end
        wb(1'b1, ADR_CMD, 32'h1);
        wb(1'b0, ADR_CTRL, 32'h10);
        wb(1'b0, ADR_SRCSEL, 32'h0);
        wb(1'b0, ADR_SUSP, 32'h0);
        wb(1'b1, ADR_SUSP, 32'h40);
        scen(32'h010, 8'h4, 2'h0, 6'h03);
        chk(susp, 1'b1);
        wb(1'b1, ADR_CMD, 32'h2);
        tick(3);
        chk(susp, 1'b0);
        wb(1'b1, ADR_CTRL, 32'h18);
        @(posedge clk_i) range_bp_i <= 1'b1;
        tick(3);
        chk(rng, 1'b0);
        chk(rng2, 1'b1);
        @(posedge clk_i) range_single_i <= 1'b1;
        tick(3);
        chk(rng, 1'b1);
        for (int j = 0; j < 2; j++) begin
            v = 16'($urandom_range(65520, 0));
            ev_status_i <= 4'($urandom);
            wb(1'b1, j ? ADR_CNTY : ADR_CNTX, {16'h0, v});
            repeat (3) pulse(4'h4 << j);
            wb(1'b0, j ? ADR_CNTY : ADR_CNTX, {16'h0, v + 16'h3});
        end
        wb(1'b1, ADR_CNTX, 32'h0);
        wb(1'b1, ADR_CNTY, 32'hffff);
        pulse(4'hc);
        wb(1'b0, ADR_STAT, {24'h0, 4'h0, ev_status_i});
        chk(dat2, {24'h0, ev_status_i, ev_status_i});
        wb(1'b0, ADR_CNTY, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h110);
        @(posedge clk_i) src <= 8'h4;
        tick(3);
        chk({halt, in_oe, halt2, in_oe2}, 4'b0110);
        @(posedge clk_i) src <= 8'h0;
        tick(3);
        end_sim();
    end
endmodule // mbm_break_matrix_bench
`default_nettype wire
